// [inc/regulation_flags_pkg.sv]
// regulation status flag block: offsets, field positions, reset values, carrier types
// assumes an 8-bit register port driven by the device's serial interface logic
package regulation_flags_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OUTPUT_REGULATION_FLAGS_OFS = 8'h01;
  localparam logic [7:0] GROUP_INTERRUPT_UNMASK_OFS  = 8'h02;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         NUM_OUTPUTS        = 3;
  localparam int         LOW_FLAG_LSB       = 3;
  localparam int         GOOD_FLAG_LSB      = 0;
  localparam int         VOLTAGE_FAULT_BIT  = 4;
  localparam int         OTP_READ_BIT       = 0;
  localparam logic [5:0] FLAGS_RESET        = 6'h00;
  localparam logic [7:0] UNMASK_RESET       = 8'h01;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : regulation_flags_pkg

// [rtl/output_regulation_status_flags.sv]
// sticky in/out-of-regulation flags for outputs a, b, c plus the group unmask register
// assumes all inputs are synchronous to clk_sys_in and one write per cycle at most
//
// Operation
// - six flags at offset 0x01, reset zero
// - leaving regulation sets low flag, sticky
// - entering regulation sets good flag, sticky
// - writing one to a flag clears it unless a same-cycle event sets it
// - tiny target changes set neither flag
// - mode switch may set output b low
// - group unmask bit gates summary flag into irq
// - otp-read unmask resets one, others zero
// - any unmasked output flag sets fault summary
`timescale 1ns/1ps
module output_regulation_status_flags
  import regulation_flags_pkg::*;
#(
  parameter int N_OUT = NUM_OUTPUTS
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire reg_req_s         reg_req_in,
  input  wire logic [N_OUT-1:0] regulating_now_in,
  input  wire logic [5:0]       out_flag_unmask_in,
  input  wire logic [7:0]       group_status_in,
  output logic [7:0]            reg_rdata_out,
  output logic [5:0]            regulation_flags_out,
  output logic [7:0]            group_interrupt_unmask_out,
  output logic                  voltage_fault_summary_out,
  output logic                  irq_out
);

  // ----------------------------------------------------------------
  // transition detection
  // ----------------------------------------------------------------
  logic [N_OUT-1:0] prev_reg_q;
  logic [N_OUT-1:0] low_evt;
  logic [N_OUT-1:0] good_evt;
  logic [5:0]       flags_q;
  logic [5:0]       flags_d;
  logic [7:0]       unmask_q;
  logic             wr_flags;
  logic             wr_unmask;
  logic [7:0]       group_live;
  logic             fault_any;
  logic             irq_any;

  // an output already regulating when reset lifts reads as an entry: good flag set
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      prev_reg_q <= '0;
    end else begin
      prev_reg_q <= regulating_now_in;
    end
  end

  // events come only from real live-bit edges, so a target step too small to
  // drop regulation (or a mode switch that does drop it) behaves naturally
  assign low_evt  = prev_reg_q & ~regulating_now_in;
  assign good_evt = ~prev_reg_q & regulating_now_in;

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  assign wr_flags  = reg_req_in.wr && (reg_req_in.addr == OUTPUT_REGULATION_FLAGS_OFS);
  assign wr_unmask = reg_req_in.wr && (reg_req_in.addr == GROUP_INTERRUPT_UNMASK_OFS);

  generate
    for (genvar i = 0; i < N_OUT; i++) begin : g_flag
      // set applied after clear so a same-cycle event is never lost
      always_comb begin
        flags_d[LOW_FLAG_LSB+i]  = flags_q[LOW_FLAG_LSB+i];
        flags_d[GOOD_FLAG_LSB+i] = flags_q[GOOD_FLAG_LSB+i];
        if (wr_flags && reg_req_in.wdata[LOW_FLAG_LSB+i]) begin
          flags_d[LOW_FLAG_LSB+i] = 1'b0;
        end
        if (wr_flags && reg_req_in.wdata[GOOD_FLAG_LSB+i]) begin
          flags_d[GOOD_FLAG_LSB+i] = 1'b0;
        end
        if (low_evt[i]) begin
          flags_d[LOW_FLAG_LSB+i] = 1'b1;
        end
        if (good_evt[i]) begin
          flags_d[GOOD_FLAG_LSB+i] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // group unmask register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      unmask_q <= UNMASK_RESET;
    end else if (wr_unmask) begin
      unmask_q <= reg_req_in.wdata;
    end
  end

  // ----------------------------------------------------------------
  // summary and interrupt
  // ----------------------------------------------------------------
  // the fault bit of the incoming group status is replaced by our own summary
  assign fault_any = |(flags_q & out_flag_unmask_in);
  always_comb begin
    group_live                    = group_status_in;
    group_live[VOLTAGE_FAULT_BIT] = fault_any;
  end
  // one named level per registered output so the checks can look back at it
  assign irq_any = |(group_live & unmask_q);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      voltage_fault_summary_out <= 1'b0;
      irq_out                   <= 1'b0;
    end else begin
      voltage_fault_summary_out <= fault_any;
      irq_out                   <= irq_any;
    end
  end

  // ----------------------------------------------------------------
  // register read-back and state outputs
  // ----------------------------------------------------------------
  // reserved bits 7:6 read zero; writes there are dropped, the host keeps them zero
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out              <= 8'h00;
      regulation_flags_out       <= FLAGS_RESET;
      group_interrupt_unmask_out <= UNMASK_RESET;
    end else begin
      regulation_flags_out       <= flags_d;
      group_interrupt_unmask_out <= wr_unmask ? reg_req_in.wdata : unmask_q;
      case (reg_req_in.addr)
        OUTPUT_REGULATION_FLAGS_OFS: reg_rdata_out <= {2'b00, flags_q};
        GROUP_INTERRUPT_UNMASK_OFS:  reg_rdata_out <= unmask_q;
        default:                     reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // all checks share the system clock and drop out while reset is high
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------------------------------
  // flag checks
  // ----------------------------------------------------------------
  low_flag_set_a: assert property (low_evt[0] |=> flags_q[LOW_FLAG_LSB])
    else $error("low flag a not set on leaving regulation");
  good_flag_set_a: assert property (good_evt[1] |=> flags_q[GOOD_FLAG_LSB+1])
    else $error("good flag b not set on entering regulation");
  w1c_clear_a: assert property (
    wr_flags && reg_req_in.wdata[2] && !good_evt[2] |=> !flags_q[2])
    else $error("write one did not clear flag");
  flag_sticky_a: assert property (
    flags_q[5] && !(wr_flags && reg_req_in.wdata[5]) |=> flags_q[5])
    else $error("low flag c dropped without a clearing write");
  no_spurious_a: assert property (!flags_q[3] && !low_evt[0] |=> !flags_q[3])
    else $error("low flag a set without a transition");
  set_wins_a: assert property (
    low_evt[1] && wr_flags && reg_req_in.wdata[4] |=> flags_q[4])
    else $error("clear beat a same-cycle set");

  // ----------------------------------------------------------------
  // read-back checks
  // ----------------------------------------------------------------
  reserved_zero_a: assert property (
    ##1 reg_rdata_out[7:6] == 2'b00 || $past(reg_req_in.addr) != OUTPUT_REGULATION_FLAGS_OFS)
    else $error("reserved bits read nonzero");
  read_flags_a: assert property (
    $past(reg_req_in.addr) == OUTPUT_REGULATION_FLAGS_OFS
    |-> reg_rdata_out == {2'b00, $past(flags_q)})
    else $error("flag read-back differs from flag register");
  read_unmask_a: assert property (
    $past(reg_req_in.addr) == GROUP_INTERRUPT_UNMASK_OFS
    |-> reg_rdata_out == $past(unmask_q))
    else $error("unmask read-back differs from unmask register");
  flags_mirror_a: assert property (regulation_flags_out == flags_q)
    else $error("flag output differs from flag register");

  // ----------------------------------------------------------------
  // unmask and interrupt checks
  // ----------------------------------------------------------------
  // the edge that leaves reset still shows reset values, so a look back into reset is excused
  unmask_reset_a: assert property ($past(reset_in) |-> unmask_q == UNMASK_RESET)
    else $error("unmask register left reset with a wrong value");
  unmask_write_a: assert property (
    wr_unmask |=> unmask_q == $past(reg_req_in.wdata))
    else $error("unmask write not taken");
  unmask_hold_a: assert property (
    !wr_unmask |=> unmask_q == $past(unmask_q))
    else $error("unmask register changed without a write");
  summary_a: assert property (
    voltage_fault_summary_out == $past(fault_any) || $past(reset_in))
    else $error("summary differs from unmasked flags");
  irq_gate_a: assert property (
    irq_out == $past(irq_any) || $past(reset_in))
    else $error("irq differs from unmasked group flags");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  low_seen_c:    cover property (low_evt[1] ##1 flags_q[4]);
  good_seen_c:   cover property (good_evt[2] ##1 flags_q[2]);
  irq_seen_c:    cover property (voltage_fault_summary_out ##1 irq_out);
  clear_seen_c:  cover property (flags_q[0] ##1 !flags_q[0]);
  set_wins_c:    cover property (low_evt[1] && wr_flags && reg_req_in.wdata[4] ##1 flags_q[4]);

endmodule : output_regulation_status_flags

// [sim/host_model.sv]
// host side model: register reads and writes, one request per cycle
// assumes the flag block samples requests on the rising clock edge
`timescale 1ns/1ps
module host_model
  import regulation_flags_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rdata_in,
  output reg_req_s        req_out
);
  initial req_out = '0;
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  // reserved bits 7:6 of the flag register are always sent as zero
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    req_out <= '{addr: a, wr: 1'b1, wdata: (a == 8'h01) ? (d & 8'h3f) : d};
    @(posedge clk_sys_in);
    req_out.wr <= 1'b0;
  endtask : write_reg
  // idle write data is inverted so stale values never look valid
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    req_out <= '{addr: a, wr: 1'b0, wdata: ~req_out.wdata};
    @(posedge clk_sys_in);
    #1 d = rdata_in;
  endtask : read_reg
endmodule : host_model

// [sim/output_regulation_status_flags_tb.sv]
// self-checking bench for the regulation flag block
// assumes host_model drives the register port; live bits come from here
`timescale 1ns/1ps
module output_regulation_status_flags_tb;
  import regulation_flags_pkg::*;
  logic       clk_sys_in, reset_in, summary, irq;
  reg_req_s   req;
  logic [2:0] live;
  logic [5:0] vmask, flags;
  logic [7:0] gstat, rdata, gmask;
  int         fail_count = 0;
  int         tests_run = 0;

  output_regulation_status_flags output_regulation_status_flags_i (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_req_in(req),
    .regulating_now_in(live), .out_flag_unmask_in(vmask), .group_status_in(gstat),
    .reg_rdata_out(rdata), .regulation_flags_out(flags),
    .group_interrupt_unmask_out(gmask), .voltage_fault_summary_out(summary),
    .irq_out(irq));
  host_model host_model_i (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .req_out(req));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_model_i.read_reg(a, v);
    chk(v, exp);
  endtask : rd_chk
  // summary and irq are registered one edge after their cause
  task automatic pause;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : pause
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    fail_count++;
    close_out();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    reset_in = 1'b1; live = 3'h0; vmask = 6'h00; gstat = 8'h01;
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h01);
    chk({7'h0, irq}, 8'h01);
    @(posedge clk_sys_in) gstat <= 8'h00;
    live <= 3'h7;
    rd_chk(8'h01, 8'h07);
    chk({2'h0, flags}, 8'h07);
    chk({7'h0, summary}, 8'h00);
    host_model_i.write_reg(8'h01, 8'h01);
    rd_chk(8'h01, 8'h06);
    // good flag a is clear while output a still regulates: only the live bit tells
    chk({2'h0, flags}, 8'h06);
    @(posedge clk_sys_in) live <= 3'h5;
    rd_chk(8'h01, 8'h16);
    host_model_i.write_reg(8'h01, 8'h06);
    rd_chk(8'h01, 8'h10);
    @(posedge clk_sys_in) vmask <= 6'h10;
    pause();
    chk({6'h0, summary, irq}, 8'h02);
    host_model_i.write_reg(8'h02, 8'h10);
    pause();
    chk({7'h0, irq}, 8'h01);
    chk(gmask, 8'h10);
    @(posedge clk_sys_in) vmask <= 6'h08;
    pause();
    chk({6'h0, summary, irq}, 8'h00);
    host_model_i.write_reg(8'h05, 8'hff);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h01, 8'h10);
    // output b re-enters, then drops in the very cycle its low flag is cleared
    @(posedge clk_sys_in) live <= 3'h7;
    fork
      host_model_i.write_reg(8'h01, 8'h12);
      @(posedge clk_sys_in) live <= 3'h5;
    join
    rd_chk(8'h01, 8'h10);
    chk({2'h0, flags}, 8'h10);
    host_model_i.write_reg(8'h01, 8'hff);
    rd_chk(8'h01, 8'h00);
    // a mid-run reset must re-arm the otp-read path to the irq pin
    @(posedge clk_sys_in) reset_in <= 1'b1;
    gstat <= 8'h01;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rd_chk(8'h02, 8'h01);
    chk(gmask, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd_chk(8'h01, 8'h05);
    close_out();
  end
endmodule : output_regulation_status_flags_tb
